// >>> fps_consts.svh
// Constants for the fault protection sequencer.
`ifndef FPS_CONSTS_SVH
`define FPS_CONSTS_SVH
`define FPS_CYC_CNT_W   4
`define FPS_OCP_RST     1'b0
`define FPS_GATE_RST    1'b0
`define FPS_STARTUP_RST 1'b1
`define FPS_HICCUP_RST  4'h0
`endif

// >>> fps_edge.sv
`timescale 1ns/100ps
// Rising-edge detector for the gate drive request, marking switching cycle starts.
module fps_edge
(
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic level,
  output logic      rise
);
  // Previous sample of the level.
  typedef struct packed
  {
    logic prev;
  } fps_edge_st_t;
  fps_edge_st_t st_r;
  fps_edge_st_t st_nxt;

  // Combinational next state.
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.prev = level;
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_r <= '0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  // Pulse is combinational so the caller registers it with its own state.
  assign rise = ce && level && !st_r.prev;
endmodule

// >>> fps_pkg.sv
// Types for the fault protection sequencer.
package fps_pkg;
  typedef enum logic [2:0] {
    FPS_OFF,
    FPS_RUN,
    FPS_WARN,
    FPS_OC_STOP,
    FPS_OT_STOP,
    FPS_OT_DRAIN
  } fps_state_t;
endpackage

// >>> fps_supply.sv
`timescale 1ns/100ps
// Supply capacitor model that turns the generator and chip draw into level flags.
module fps_supply
(
  input  wire logic ref_clk,
  input  wire logic startup_en,
  input  wire logic drain,
  output logic      above_on_level,
  output logic      above_off_level,
  output logic      below_restart_level
);
  int v = 0; // Supply charge in arbitrary steps.
  // Chip draw wins over the generator, so the bench can force a hiccup at will.
  always @(posedge ref_clk)
  begin
    if (drain)
      v <= (v > 0) ? v - 1 : 0;
    else if (startup_en)
      v <= (v < 20) ? v + 1 : 20;
  end
  assign above_on_level      = v >= 12;
  assign above_off_level     = v >= 6;
  assign below_restart_level = v < 3;
endmodule

// >>> fps_top.sv
`timescale 1ns/100ps
// Fault protection sequencer: overcurrent filter, thermal shutdown and hiccup restart.
`include "fps_consts.svh"

// Behaviour
// - Watch overcurrent comparator flag continuously.
// - First overcurrent trip enters warning state.
// - Clean next cycle returns to run.
// - Second trip next cycle stops switching.
// - Overcurrent stop holds until supply below restart.
// - Start-up generator stays on during stop.
// - Overtemperature stops switching, recycles supply.
// - Overtemperature clear resumes unless supply below turn-off.
// - Else discharge to restart, recharge, then start.
// - Undervoltage lockout forces gate drive low.
module fps_top
  import fps_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic pwm_req,
  input  wire logic oc_flag,
  input  wire logic ot_flag,
  input  wire logic above_on_level,
  input  wire logic above_off_level,
  input  wire logic below_restart_level,
  output logic      gate_en,
  output logic      startup_en,
  output logic      fault_oc,
  output logic      fault_ot
);
  // Whole state of the sequencer in one packed record.
  typedef struct packed
  {
    fps_state_t state;      // Protection state.
    logic       oc_seen;    // Overcurrent seen in the cycle after a warning.
    logic       gate;       // Registered gate enable.
    logic       startup;    // Registered start-up generator enable.
    logic       f_oc;       // Overcurrent stop indicator.
    logic       f_ot;       // Thermal stop indicator.
  } fps_st_t;
  fps_st_t st_r;
  fps_st_t st_nxt;
  logic    cyc_start;       // One-cycle pulse at each gate turn-on.
  logic    undervoltage_lockout;            // Undervoltage lockout, supply below turn-off.

  // Gate turn-on edges mark switching cycle boundaries.
  fps_edge u_edge
  (
    .ref_clk (ref_clk),
    .srst    (srst),
    .ce      (ce),
    .level   (pwm_req && st_r.state inside {FPS_RUN, FPS_WARN}),
    .rise    (cyc_start)
  );

  assign undervoltage_lockout = !above_off_level;

  // Supply management used by the thermal stop state: charge up from restart level.
  function automatic logic charge_need(input logic on_lvl, input logic cur);
    // Start-up generator charges until turn-on level, then lets supply sag.
    charge_need = on_lvl ? 1'b0 : cur;
  endfunction

  // Next-state logic of the protection sequencer.
  always_comb
  begin
    st_nxt = st_r;
    case (st_r.state)
      FPS_OFF:
      begin
        // Waiting for supply to reach turn-on level with the generator charging.
        st_nxt.startup = 1'b1;
        if (above_on_level && !ot_flag)
        begin
          st_nxt.state   = FPS_RUN;
          st_nxt.startup = 1'b0;
        end
      end
      FPS_RUN:
      begin
        if (oc_flag)
        begin
          st_nxt.state   = FPS_WARN;
          st_nxt.oc_seen = 1'b0;
        end
      end
      FPS_WARN:
      begin
        // The warning window runs from the trip up to the next gate turn-on.
        if (oc_flag && !cyc_start)
        begin
          st_nxt.oc_seen = 1'b1;
        end
        if (cyc_start)
        begin
          if (st_r.oc_seen)
          begin
            st_nxt.state = FPS_OC_STOP;
          end
          else
          begin
            st_nxt.state = FPS_RUN;
          end
          st_nxt.oc_seen = 1'b0;
        end
      end
      FPS_OC_STOP:
      begin
        st_nxt.startup = 1'b1;
        if (below_restart_level)
        begin
          st_nxt.state = FPS_OFF;
        end
      end
      FPS_OT_STOP:
      begin
        // Cycle supply between turn-on and restart levels to keep alive.
        if (below_restart_level)
        begin
          st_nxt.startup = 1'b1;
        end
        else
        begin
          st_nxt.startup = charge_need(above_on_level, st_r.startup);
        end
        if (!ot_flag)
        begin
          if (above_off_level)
          begin
            st_nxt.state   = FPS_RUN;
            st_nxt.startup = 1'b0;
          end
          else
          begin
            st_nxt.state   = FPS_OT_DRAIN;
            st_nxt.startup = 1'b0;
          end
        end
      end
      FPS_OT_DRAIN:
      begin
        // Let supply discharge to restart level, then recharge via the off state.
        st_nxt.startup = 1'b0;
        if (below_restart_level)
        begin
          st_nxt.state = FPS_OFF;
        end
      end
      default:
      begin
        st_nxt.state = FPS_OFF;
      end
    endcase
    // Thermal shutdown overrides every switching state.
    if (ot_flag && st_nxt.state inside {FPS_RUN, FPS_WARN, FPS_OFF})
    begin
      st_nxt.state = FPS_OT_STOP;
    end
    // Undervoltage lockout drops the switcher back to the off state.
    if (undervoltage_lockout && st_nxt.state inside {FPS_RUN, FPS_WARN})
    begin
      st_nxt.state = FPS_OFF;
    end
    // The generator follows the state actually entered, so the off state reached through the
    // undervoltage override charges the supply from its very first cycle.
    if (st_nxt.state == FPS_OFF || st_nxt.state == FPS_OC_STOP)
    begin
      st_nxt.startup = 1'b1;
    end
    else if (st_nxt.state == FPS_OT_STOP)
    begin
      st_nxt.startup = below_restart_level ? 1'b1
                       : charge_need(above_on_level, st_r.startup);
    end
    else
    begin
      st_nxt.startup = 1'b0;
    end
    st_nxt.gate = pwm_req && !undervoltage_lockout
                  && (st_nxt.state == FPS_RUN || st_nxt.state == FPS_WARN);
    st_nxt.f_oc = st_nxt.state == FPS_OC_STOP;
    st_nxt.f_ot = st_nxt.state inside {FPS_OT_STOP, FPS_OT_DRAIN};
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_r.state   <= FPS_OFF;
      st_r.oc_seen <= `FPS_OCP_RST;
      st_r.gate    <= `FPS_GATE_RST;
      st_r.startup <= `FPS_STARTUP_RST;
      st_r.f_oc    <= 1'b0;
      st_r.f_ot    <= 1'b0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from flip-flops.
  assign gate_en    = st_r.gate;
  assign startup_en = st_r.startup;
  assign fault_oc   = st_r.f_oc;
  assign fault_ot   = st_r.f_ot;

  // Gate is off from the cycle after the supply is seen below turn-off.
  a_gate_undervoltage_lockout_low: assert property (@(posedge ref_clk) disable iff (srst)
    ce && undervoltage_lockout |=> !gate_en) else $error("gate on under lockout");

  // Overcurrent stop keeps gate off and generator on.
  a_ocstop_hold: assert property (@(posedge ref_clk) disable iff (srst)
    fault_oc |-> !gate_en && startup_en) else $error("oc stop not held");

  // Thermal fault blocks switching.
  a_ot_no_gate: assert property (@(posedge ref_clk) disable iff (srst)
    fault_ot |-> !gate_en) else $error("gate on in thermal stop");

  // A trip while running enters the warning state unless a thermal fault or lockout overrides it.
  a_oc_to_warn: assert property (@(posedge ref_clk) disable iff (srst)
    ce && st_r.state == FPS_RUN && oc_flag && !ot_flag && !undervoltage_lockout
    |=> st_r.state == FPS_WARN) else $error("no warning on trip");

  // Clean cycle after warning returns to run.
  a_warn_clear: assert property (@(posedge ref_clk) disable iff (srst)
    ce && st_r.state == FPS_WARN && cyc_start && !st_r.oc_seen && !ot_flag && !undervoltage_lockout
    |=> st_r.state == FPS_RUN) else $error("warning not cleared");

  // Second trip ends in overcurrent stop.
  a_warn_fault: assert property (@(posedge ref_clk) disable iff (srst)
    ce && st_r.state == FPS_WARN && cyc_start && st_r.oc_seen && !ot_flag
    |=> fault_oc) else $error("no stop on second trip");

  // Overcurrent stop leaves only through restart level.
  a_ocstop_exit: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(fault_oc) |-> $past(below_restart_level)) else $error("early oc exit");

  // Thermal clear with healthy supply resumes.
  a_ot_resume: assert property (@(posedge ref_clk) disable iff (srst)
    ce && st_r.state == FPS_OT_STOP && !ot_flag && above_off_level
    |=> st_r.state == FPS_RUN) else $error("no thermal resume");
endmodule

// >>> tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for the fault protection sequencer.
module tb_top;
  logic ref_clk = 0, srst = 1, ce = 1, pwm_req = 0, oc_flag = 0, ot_flag = 0, drain = 0;
  logic on_l, off_l, rst_l, gate_en, startup_en, fault_oc, fault_ot;
  int   bad_count = 0, checked = 0, seed = 24542, cycles = 0;
  int   st = 0, memo = 0, prv = 0, g = 0, su = 1, rs, r;
  always #4 ref_clk = ~ref_clk;
  fps_top dut_u (.ref_clk(ref_clk), .srst(srst), .ce(ce), .pwm_req(pwm_req), .oc_flag(oc_flag),
    .ot_flag(ot_flag), .above_on_level(on_l), .above_off_level(off_l),
    .below_restart_level(rst_l), .gate_en(gate_en), .startup_en(startup_en),
    .fault_oc(fault_oc), .fault_ot(fault_ot));
  fps_supply sup_u (.ref_clk(ref_clk), .startup_en(startup_en), .drain(drain),
    .above_on_level(on_l), .above_off_level(off_l), .below_restart_level(rst_l));
  task automatic chk(string n, logic a, logic e);
    checked++;
    if (a !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, a);
    end
  endtask
  task conclude();
    if (bad_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Reference model: 0 off, 1 run, 2 warn, 3 oc stop, 4 thermal stop, 5 thermal drain.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (srst)
    begin
      st = 0;
      prv = 0;
      g = 0;
      su = 1;
    end
    else if (ce)
    begin
      rs = pwm_req && !prv;
      prv = pwm_req;
      case (st)
        0: st = ot_flag ? 4 : on_l ? 1 : 0;
        1: st = ot_flag ? 4 : !off_l ? 0 : oc_flag ? 2 : 1;
        2: if (rs && memo)
             st = 3;
           else if (ot_flag || !off_l)
             st = ot_flag ? 4 : 0;
           else if (rs)
             st = memo ? 3 : 1;
           else
             memo |= oc_flag;
        3: st = rst_l ? (ot_flag ? 4 : 0) : 3;
        4: st = ot_flag ? 4 : off_l ? 1 : 5;
        default: st = rst_l ? (ot_flag ? 4 : 0) : 5;
      endcase
      if (st != 2)
        memo = 0;
      g = (st == 1 || st == 2) && pwm_req && off_l;
      su = (st == 0 || st == 3) ? 1 : st != 4 ? 0 : rst_l ? 1 : on_l ? 0 : su;
    end
    // A hang is cut short here and counted as a failure.
    if (cycles > 20000)
    begin
      bad_count++;
      conclude();
    end
  end
  // Outputs are settled at the falling edge, so the model is compared there.
  always @(negedge ref_clk)
  begin
    chk("gate_en", gate_en, g[0]);
    chk("startup_en", startup_en, su[0]);
    chk("fault_oc", fault_oc, st == 3);
    chk("fault_ot", fault_ot, st >= 4);
  end
  task cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task wait_st(int s);
    repeat (300)
      if (st != s)
        @(negedge ref_clk);
  endtask
  // One switching cycle with k low-phase cycles of overcurrent, then a gate turn-on.
  task swc(int k);
    pwm_req = 0;
    oc_flag = k > 0;
    cyc(k);
    if (k > 0)
      oc_flag = 0;
    cyc(3 - k);
    pwm_req = 1;
    cyc(2);
  endtask
  initial
  begin
    cyc(6);
    srst = 0;
    wait_st(1);
    swc(0);
    chk("gate run", gate_en, 1);
    swc(1);
    chk("glitch", fault_oc, 0);
    swc(2);
    chk("oc stop", fault_oc, 1);
    chk("gate stop", gate_en, 0);
    chk("gen on", startup_en, 1);
    drain = 1;
    cyc(5);
    chk("oc held", fault_oc, 1);
    wait_st(0);
    drain = 0;
    chk("oc release", fault_oc, 0);
    wait_st(1);
    ot_flag = 1;
    drain = 1;
    cyc(2);
    chk("ot stop", gate_en, 0);
    repeat (300)
      if (!rst_l)
        @(negedge ref_clk);
    drain = 0;
    cyc(15);
    chk("ot recharge", startup_en, 0);
    ot_flag = 0;
    cyc(2);
    chk("ot resume", gate_en, 1);
    ot_flag = 1;
    drain = 1;
    repeat (300)
      if (off_l)
        @(negedge ref_clk);
    drain = 0;
    ot_flag = 0;
    cyc(2);
    chk("ot drain", fault_ot, 1);
    drain = 1;
    wait_st(0);
    drain = 0;
    wait_st(1);
    cyc(1);
    chk("drain restart", gate_en, 1);
    drain = 1;
    repeat (300)
      if (off_l)
        @(negedge ref_clk);
    cyc(1);
    chk("undervoltage_lockout", gate_en, 0);
    // Random traffic, including clock-enable gaps, against the model.
    repeat (4000)
    begin
      @(negedge ref_clk);
      r = $random(seed);
      pwm_req = r[0];
      oc_flag = r[1] & r[2];
      ce = r[5:3] != 3'h0;
      drain = r[6];
      ot_flag = r[11:7] == 5'h00;
    end
    conclude();
  end
endmodule
